// ===== aoft_defs.svh
// Register indices, field positions, reset values and fixed words
`ifndef AOFT_DEFS_SVH
`define AOFT_DEFS_SVH
`define AOFT_IDX_PAT_LO 8'h10
`define AOFT_IDX_PAT_HI 8'h12
`define AOFT_IDX_GAIN 8'h15
`define AOFT_IDX_CTRL 8'h16
`define AOFT_IDX_CTRL_RB 8'h17
`define AOFT_IDX_STATUS 8'h1f
`define AOFT_CTRL_RST 8'h00
`define AOFT_GAIN_RST 8'h00
`define AOFT_PAT_RST 8'h00
`define AOFT_EQ_BIT 4
`define AOFT_FMT_BIT 3
`define AOFT_MSB_BIT 2
`define AOFT_MANUAL_BIT 6
`define AOFT_IOR_BIT 7
`define AOFT_ADC_COARSE 3'h7
`define AOFT_ADC_FINE 3'h6
`define AOFT_IOR_COARSE 3'h1
`define AOFT_IOR_FINE 3'h7
`define AOFT_UNITY 11'h400
`define AOFT_IOR_FACTOR 11'h562
`define AOFT_GAIN_SHIFT 10
`define AOFT_TRAIN1 12'h03f
`define AOFT_TRAIN2 12'haaa
`define AOFT_LAST_BIT 4'hb
`define AOFT_HALF_WORD 4'h6
`define AOFT_RESP_OKAY 2'h0
`define AOFT_RESP_SLVERR 2'h2
`endif

// ===== aoft_pkg.sv
// Types shared by the output format and training block
package aoft_pkg;
  typedef enum logic [1:0] {
    AOFT_TS_DATA = 2'h0,
    AOFT_TS_STEP = 2'h1,
    AOFT_TS_ALT = 2'h2,
    AOFT_TS_CUSTOM = 2'h3
  } aoft_tsel_t;
  typedef enum logic [1:0] {
    AOFT_WR_IDLE = 2'h0,
    AOFT_WR_ADDR = 2'h1,
    AOFT_WR_RESP = 2'h3,
    AOFT_WR_DATA = 2'h2
  } aoft_wr_state_t;
  typedef enum logic {
    AOFT_RD_IDLE = 1'b0,
    AOFT_RD_DATA = 1'b1
  } aoft_rd_state_t;
endpackage

// ===== aoft_serializer.sv
// Word-aligned serializer with training pattern selection
`timescale 1ns/1ps
`include "aoft_defs.svh"
module aoft_serializer (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Synchronised link clock level and its rising edge
  input wire logic link_lvl_i,
  input wire logic bit_tick_i,
  // Word sources and settings
  input wire logic [11:0] sample_i,
  input wire logic [1:0] tsel_i,
  input wire logic fmt_i,
  input wire logic msb_i,
  input wire logic [11:0] custom_i,
  // Serial outputs
  output logic ser_data_o,
  output logic bit_clk_o,
  output logic word_clk_o,
  output logic [3:0] active_o
);
  logic [3:0] cnt_reg, cnt_next;
  logic [11:0] word_reg, word_next;
  logic [1:0] tsel_act_reg, tsel_act_next;
  logic fmt_act_reg, fmt_act_next, msb_act_reg, msb_act_next;
  logic ser_reg, ser_next, bclk_reg, bclk_next, wclk_reg, wclk_next;
  logic [11:0] sel_word;
  logic load;
  always_comb begin
    case (aoft_pkg::aoft_tsel_t'(tsel_i))
      aoft_pkg::AOFT_TS_DATA: sel_word = fmt_i ? {~sample_i[11], sample_i[10:0]} : sample_i;
      aoft_pkg::AOFT_TS_STEP: sel_word = `AOFT_TRAIN1;
      aoft_pkg::AOFT_TS_ALT: sel_word = `AOFT_TRAIN2;
      aoft_pkg::AOFT_TS_CUSTOM: sel_word = custom_i;
      default: sel_word = sample_i;
    endcase
  end
  assign load = bit_tick_i && (cnt_reg == `AOFT_LAST_BIT);
  always_comb begin
    cnt_next = cnt_reg;
    word_next = word_reg;
    tsel_act_next = tsel_act_reg;
    fmt_act_next = fmt_act_reg;
    msb_act_next = msb_act_reg;
    ser_next = ser_reg;
    bclk_next = link_lvl_i;
    if (load) begin
      // Settings latch only here, so no word mixes old and new
      cnt_next = 4'h0;
      word_next = sel_word;
      tsel_act_next = tsel_i;
      fmt_act_next = fmt_i;
      msb_act_next = msb_i;
      ser_next = msb_i ? sel_word[11] : sel_word[0];
    end else if (bit_tick_i) begin
      cnt_next = cnt_reg + 4'h1;
      ser_next = msb_act_reg ? word_reg[`AOFT_LAST_BIT - cnt_next] : word_reg[cnt_next];
    end
    wclk_next = (cnt_next < `AOFT_HALF_WORD);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= `AOFT_LAST_BIT;
      word_reg <= 12'h000;
      tsel_act_reg <= 2'h0;
      fmt_act_reg <= 1'b0;
      msb_act_reg <= 1'b0;
      ser_reg <= 1'b0;
      bclk_reg <= 1'b0;
      wclk_reg <= 1'b0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
      word_reg <= word_next;
      tsel_act_reg <= tsel_act_next;
      fmt_act_reg <= fmt_act_next;
      msb_act_reg <= msb_act_next;
      ser_reg <= ser_next;
      bclk_reg <= bclk_next;
      wclk_reg <= wclk_next;
    end
  end
  assign ser_data_o = ser_reg;
  assign bit_clk_o = bclk_reg;
  assign word_clk_o = wclk_reg;
  assign active_o = {msb_act_reg, fmt_act_reg, tsel_act_reg};
  property p_bclk_runs;
    @(posedge clk_i) disable iff (rst_i) ce_i && bit_tick_i |=> bit_clk_o;
  endproperty
  a_bclk_runs: assert property (p_bclk_runs) else $error("bit clock stalled");
  property p_cfg_held;
    @(posedge clk_i) disable iff (rst_i) !(ce_i && load) |=> $stable(tsel_act_reg) && $stable(word_reg);
  endproperty
  a_cfg_held: assert property (p_cfg_held) else $error("word changed mid-word");
  property p_train_step;
    @(posedge clk_i) disable iff (rst_i) ce_i && load && tsel_i == 2'h1 |=> word_reg == 12'h03f;
  endproperty
  a_train_step: assert property (p_train_step) else $error("wrong step word");
  property p_train_alt;
    @(posedge clk_i) disable iff (rst_i) ce_i && load && tsel_i == 2'h2 |=> word_reg == 12'haaa;
  endproperty
  a_train_alt: assert property (p_train_alt) else $error("wrong alternating word");
  property p_custom;
    @(posedge clk_i) disable iff (rst_i) ce_i && load && tsel_i == 2'h3 |=> word_reg == $past(custom_i);
  endproperty
  a_custom: assert property (p_custom) else $error("wrong custom word");
  property p_first_bit;
    @(posedge clk_i) disable iff (rst_i) ce_i && load |=> ser_data_o == (msb_act_reg ? word_reg[11] : word_reg[0]);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("wrong first bit");
  property p_offset_bin;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && load && tsel_i == 2'h0 && fmt_i |=> word_reg[11] != $past(sample_i[11]);
  endproperty
  a_offset_bin: assert property (p_offset_bin) else $error("sign not inverted");
  c_step: cover property (@(posedge clk_i) disable iff (rst_i) ce_i && load && tsel_i == 2'h1);
  c_custom: cover property (@(posedge clk_i) disable iff (rst_i) ce_i && load && tsel_i == 2'h3);
  c_msb: cover property (@(posedge clk_i) disable iff (rst_i) ce_i && load && msb_i && tsel_i == 2'h0);
endmodule

// ===== aoft_top.sv
// Output format, digital gain and training pattern block with AXI4-Lite registers
// What this block does
// - Coarse 111 with fine 110 gives 0 dB gain (2.10 Vpp) and is the normal-mode default.
// - In overload recovery mode the default gain is coarse 001, fine 111, giving 2.58 dB (1.56 Vpp).
// - Fine code 011 acts as 2, codes 100 and 101 act as -2; 010=2, 001=1, 000=0, 111=-1, 110=-2.
// - The control register at 16h is write-only and its contents read back at 17h.
// - Control bit 4 turns the equalizer on, shortening group delay.
// - Control bit 3 picks two's complement (0) or offset binary (1).
// - Control bit 2 picks least significant bit first (0) or most significant first (1).
// - Selector 00 sends data, 01 sends 000000111111, 10 sends 101010101010, 11 the custom word.
// - Any training selection sends its 12-bit word every word period instead of data.
// - The custom word comes from the pattern registers at 10h and 12h.
// - Bit clock and word clock run the same whatever the selection.
// - After reset the control register is zero: data, two's complement, LSB first, equalizer off.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "aoft_defs.svh"
module aoft_top #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter samples, two's complement
  input wire logic [11:0] sample_i,
  input wire logic sample_valid_i,
  // Link clock from outside
  input wire logic link_clk_i,
  // Serial lane
  output logic ser_data_o,
  output logic bit_clk_o,
  output logic word_clk_o
);
  if (ADDR_W < 7) begin : g_chk
    $error("ADDR_W too small for the register map");
  end
  aoft_pkg::aoft_wr_state_t wst_reg, wst_next;
  aoft_pkg::aoft_rd_state_t rst_st_reg, rst_st_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic wstrb_reg, wstrb_next;
  logic awready_reg, awready_next, wready_reg, wready_next, bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] ctrl_reg, ctrl_next, gain_reg, gain_next, pat_lo_reg, pat_lo_next, pat_hi_reg, pat_hi_next;
  logic do_wr, wr_ok;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_en;
  logic [3:0] active;
  function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = 8'(a[ADDR_W-1:2]);
  endfunction
  // Write channel: address and data may arrive in either order
  always_comb begin
    wst_next = wst_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    do_wr = 1'b0;
    wr_addr = s_axi_awaddr;
    wr_byte = s_axi_wdata[7:0];
    wr_en = s_axi_wstrb[0];
    // A channel is taken only while its ready stands high
    case (wst_reg)
      aoft_pkg::AOFT_WR_IDLE: begin
        if (s_axi_awvalid && awready_reg && s_axi_wvalid && wready_reg) begin
          do_wr = 1'b1;
        end else if (s_axi_awvalid && awready_reg) begin
          awaddr_next = s_axi_awaddr;
          wst_next = aoft_pkg::AOFT_WR_ADDR;
        end else if (s_axi_wvalid && wready_reg) begin
          wdata_next = s_axi_wdata[7:0];
          wstrb_next = s_axi_wstrb[0];
          wst_next = aoft_pkg::AOFT_WR_DATA;
        end
      end
      aoft_pkg::AOFT_WR_ADDR: begin
        wr_addr = awaddr_reg;
        do_wr = s_axi_wvalid && wready_reg;
      end
      aoft_pkg::AOFT_WR_DATA: begin
        wr_byte = wdata_reg;
        wr_en = wstrb_reg;
        do_wr = s_axi_awvalid && awready_reg;
      end
      aoft_pkg::AOFT_WR_RESP: begin
        if (s_axi_bready) begin
          wst_next = aoft_pkg::AOFT_WR_IDLE;
        end
      end
      default: wst_next = aoft_pkg::AOFT_WR_IDLE;
    endcase
    case (idx_of(wr_addr))
      `AOFT_IDX_PAT_LO, `AOFT_IDX_PAT_HI, `AOFT_IDX_GAIN, `AOFT_IDX_CTRL: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
    if (do_wr) begin
      wst_next = aoft_pkg::AOFT_WR_RESP;
      bresp_next = wr_ok ? `AOFT_RESP_OKAY : `AOFT_RESP_SLVERR;
    end
    awready_next = (wst_next == aoft_pkg::AOFT_WR_IDLE) || (wst_next == aoft_pkg::AOFT_WR_DATA);
    wready_next = (wst_next == aoft_pkg::AOFT_WR_IDLE) || (wst_next == aoft_pkg::AOFT_WR_ADDR);
    bvalid_next = (wst_next == aoft_pkg::AOFT_WR_RESP);
  end
  // Register writes; reserved control bits are stored as written
  always_comb begin
    ctrl_next = ctrl_reg;
    gain_next = gain_reg;
    pat_lo_next = pat_lo_reg;
    pat_hi_next = pat_hi_reg;
    if (do_wr && wr_en) begin
      case (idx_of(wr_addr))
        `AOFT_IDX_CTRL: ctrl_next = wr_byte;
        `AOFT_IDX_GAIN: gain_next = wr_byte;
        `AOFT_IDX_PAT_LO: pat_lo_next = wr_byte;
        `AOFT_IDX_PAT_HI: pat_hi_next = {4'h0, wr_byte[3:0]};
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end
  // Read channel; the write-only control address answers with an error
  always_comb begin
    rst_st_next = rst_st_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rst_st_reg)
      aoft_pkg::AOFT_RD_IDLE: begin
        if (s_axi_arvalid && arready_reg) begin
          rst_st_next = aoft_pkg::AOFT_RD_DATA;
          rresp_next = `AOFT_RESP_OKAY;
          case (idx_of(s_axi_araddr))
            `AOFT_IDX_PAT_LO: rdata_next = {24'h000000, pat_lo_reg};
            `AOFT_IDX_PAT_HI: rdata_next = {24'h000000, pat_hi_reg};
            `AOFT_IDX_GAIN: rdata_next = {24'h000000, gain_reg};
            `AOFT_IDX_CTRL_RB: rdata_next = {24'h000000, ctrl_reg};
            `AOFT_IDX_STATUS: rdata_next = {27'h0000000, ctrl_reg[`AOFT_EQ_BIT], active};
            default: begin
              rdata_next = 32'h00000000;
              rresp_next = `AOFT_RESP_SLVERR;
            end
          endcase
        end
      end
      aoft_pkg::AOFT_RD_DATA: begin
        if (s_axi_rready) begin
          rst_st_next = aoft_pkg::AOFT_RD_IDLE;
        end
      end
      default: rst_st_next = aoft_pkg::AOFT_RD_IDLE;
    endcase
    arready_next = (rst_st_next == aoft_pkg::AOFT_RD_IDLE);
    rvalid_next = (rst_st_next == aoft_pkg::AOFT_RD_DATA);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wst_reg <= aoft_pkg::AOFT_WR_IDLE;
      rst_st_reg <= aoft_pkg::AOFT_RD_IDLE;
      awaddr_reg <= '0;
      wdata_reg <= 8'h00;
      wstrb_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `AOFT_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= `AOFT_RESP_OKAY;
      rdata_reg <= 32'h00000000;
      ctrl_reg <= `AOFT_CTRL_RST;
      gain_reg <= `AOFT_GAIN_RST;
      pat_lo_reg <= `AOFT_PAT_RST;
      pat_hi_reg <= `AOFT_PAT_RST;
    end else if (ce_i) begin
      wst_reg <= wst_next;
      rst_st_reg <= rst_st_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      ctrl_reg <= ctrl_next;
      gain_reg <= gain_next;
      pat_lo_reg <= pat_lo_next;
      pat_hi_reg <= pat_hi_next;
    end
  end
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  // Code to step offset 0..4; unused codes fold onto the nearest end
  function automatic logic [2:0] code_step(input logic [2:0] c);
    case (c)
      3'h2, 3'h3: code_step = 3'h4;
      3'h1: code_step = 3'h3;
      3'h0: code_step = 3'h2;
      3'h7: code_step = 3'h1;
      default: code_step = 3'h0;
    endcase
  endfunction
  // Q10 gain factor, one step per table row, 2.10 Vpp is unity
  function automatic logic [10:0] gain_lut(input logic [4:0] i);
    case (i)
      5'h00: gain_lut = 11'h363;
      5'h01: gain_lut = 11'h388;
      5'h02: gain_lut = 11'h3af;
      5'h03: gain_lut = 11'h3da;
      5'h04: gain_lut = 11'h400;
      5'h05: gain_lut = 11'h429;
      5'h06: gain_lut = 11'h44f;
      5'h07: gain_lut = 11'h478;
      5'h08: gain_lut = 11'h49e;
      5'h09: gain_lut = 11'h4c6;
      5'h0a: gain_lut = 11'h4ea;
      5'h0b: gain_lut = 11'h517;
      5'h0c: gain_lut = 11'h538;
      5'h0d: gain_lut = 11'h562;
      5'h0e: gain_lut = 11'h587;
      5'h0f: gain_lut = 11'h5ad;
      5'h10: gain_lut = 11'h5d5;
      5'h11: gain_lut = 11'h600;
      5'h12: gain_lut = 11'h622;
      5'h13: gain_lut = 11'h651;
      default: gain_lut = 11'h676;
    endcase
  endfunction
  logic overload_recovery_mode, manual;
  logic [2:0] coarse, fine;
  logic [10:0] factor_reg, factor_next;
  logic [11:0] d1_reg, d1_next, d2_reg, d2_next, gained_reg, gained_next, src;
  logic signed [23:0] prod;
  logic signed [13:0] scaled;
  assign overload_recovery_mode = gain_reg[`AOFT_IOR_BIT];
  assign manual = gain_reg[`AOFT_MANUAL_BIT];
  always_comb begin
    if (manual) begin
      coarse = gain_reg[5:3];
      fine = gain_reg[2:0];
    end else if (overload_recovery_mode) begin
      coarse = `AOFT_IOR_COARSE;
      fine = `AOFT_IOR_FINE;
    end else begin
      coarse = `AOFT_ADC_COARSE;
      fine = `AOFT_ADC_FINE;
    end
    factor_next = gain_lut(5'({code_step(coarse), 2'h0}) + 5'(code_step(fine)));
    d1_next = d1_reg;
    d2_next = d2_reg;
    gained_next = gained_reg;
    // Equalizer off costs one extra sample of delay
    src = ctrl_reg[`AOFT_EQ_BIT] ? d1_reg : d2_reg;
    prod = $signed(src) * $signed({1'b0, factor_reg});
    scaled = 14'(prod >>> `AOFT_GAIN_SHIFT);
    if (sample_valid_i) begin
      d1_next = sample_i;
      d2_next = d1_reg;
      if (scaled > 14'sh07ff) begin
        gained_next = 12'h7ff;
      end else if (scaled < -14'sh0800) begin
        gained_next = 12'h800;
      end else begin
        gained_next = scaled[11:0];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      factor_reg <= `AOFT_UNITY;
      d1_reg <= 12'h000;
      d2_reg <= 12'h000;
      gained_reg <= 12'h000;
    end else if (ce_i) begin
      factor_reg <= factor_next;
      d1_reg <= d1_next;
      d2_reg <= d2_next;
      gained_reg <= gained_next;
    end
  end
  // Link clock synchroniser; stage one feeds stage two only
  logic lk1_reg, lk2_reg, lk3_reg, bit_tick;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lk1_reg <= 1'b0;
      lk2_reg <= 1'b0;
      lk3_reg <= 1'b0;
    end else if (ce_i) begin
      lk1_reg <= link_clk_i;
      lk2_reg <= lk1_reg;
      lk3_reg <= lk2_reg;
    end
  end
  assign bit_tick = lk2_reg && !lk3_reg;
  aoft_serializer u_ser (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .link_lvl_i(lk2_reg),
    .bit_tick_i(bit_tick),
    .sample_i(gained_reg),
    .tsel_i(ctrl_reg[1:0]),
    .fmt_i(ctrl_reg[`AOFT_FMT_BIT]),
    .msb_i(ctrl_reg[`AOFT_MSB_BIT]),
    .custom_i({pat_hi_reg[3:0], pat_lo_reg}),
    .ser_data_o(ser_data_o),
    .bit_clk_o(bit_clk_o),
    .word_clk_o(word_clk_o),
    .active_o(active)
  );
  property p_adc_default;
    @(posedge clk_i) disable iff (rst_i) ce_i && !manual && !overload_recovery_mode |=> factor_reg == 11'h400;
  endproperty
  a_adc_default: assert property (p_adc_default) else $error("normal default gain not unity");
  property p_ior_default;
    @(posedge clk_i) disable iff (rst_i) ce_i && !manual && overload_recovery_mode |=> factor_reg == 11'h562;
  endproperty
  a_ior_default: assert property (p_ior_default) else $error("overload default gain wrong");
  property p_fine_fold;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && manual && coarse == 3'h7 && fine == 3'h3 |=> factor_reg == 11'h49e;
  endproperty
  a_fine_fold: assert property (p_fine_fold) else $error("unused fine code not folded");
  property p_readback;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && s_axi_arvalid && arready_reg && idx_of(s_axi_araddr) == 8'h17
      |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(ctrl_reg)};
  endproperty
  a_readback: assert property (p_readback) else $error("control readback wrong");
  property p_reset_zero;
    @(posedge clk_i) disable iff (rst_i) $fell(rst_i) |-> ctrl_reg == 8'h00 && factor_reg == 11'h400;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("control not zero after reset");
  c_ior: cover property (@(posedge clk_i) disable iff (rst_i) overload_recovery_mode && !manual);
  c_wo_read: cover property (@(posedge clk_i) disable iff (rst_i) s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

// ===== aoft_deser_model.sv
// Receiving deserializer model that frames words on the word clock
`timescale 1ns/1ps
module aoft_deser_model (
  // Serial lane from the block
  input wire logic ser_i,
  input wire logic bit_clk_i,
  input wire logic word_clk_i,
  // Last complete word, bits in arrival order
  output logic [11:0] word_o,
  output logic [4:0] len_o,
  output int cnt_o
);
  logic [11:0] buf_reg;
  logic [4:0] n_reg;
  logic wclk_reg;
  initial begin
    word_o = 12'h000;
    len_o = 5'h00;
    cnt_o = 0;
    buf_reg = 12'h000;
    n_reg = 5'h00;
    wclk_reg = 1'b0;
  end
  // Mid-bit sampling on the falling edge, away from data changes
  always @(negedge bit_clk_i) begin
    if (word_clk_i && !wclk_reg) begin
      word_o = buf_reg;
      len_o = n_reg;
      cnt_o = cnt_o + 1;
      buf_reg[0] = ser_i;
      n_reg = 5'h01;
    end else begin
      if (n_reg < 5'h0c) begin
        buf_reg[n_reg[3:0]] = ser_i;
      end
      n_reg = n_reg + 5'h01;
    end
    wclk_reg = word_clk_i;
  end
endmodule

// ===== tb_top.sv
// Testbench for the output format and training block
`timescale 1ns/1ps
module tb_top;
  logic clk_i, rst_i, ce_i, link_clk_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sample_valid, ser, bclk, wclk;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [11:0] sample, rx_word;
  logic [4:0] rx_len;
  int rx_cnt, error_cnt, checked;
  aoft_top #(.ADDR_W(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_i(sample), .sample_valid_i(sample_valid), .link_clk_i(link_clk_i), .ser_data_o(ser),
    .bit_clk_o(bclk), .word_clk_o(wclk));
  aoft_deser_model rx_u (.ser_i(ser), .bit_clk_i(bclk), .word_clk_i(wclk), .word_o(rx_word),
    .len_o(rx_len), .cnt_o(rx_cnt));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Link clock free running, phase unrelated to the system clock
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #160 link_clk_i = ~link_clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wr_ok(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("write response", {30'h0, r}, 32'h0);
  endtask
  // Waits for three more received words so a setting change has reached the lane
  task automatic chk_word(input string nm, input logic [11:0] w, input logic msb);
    int c;
    logic [11:0] e;
    for (int i = 0; i < 12; i++) e[i] = msb ? w[11-i] : w[i];
    c = rx_cnt + 3;
    while (rx_cnt < c) @(posedge clk_i);
    chk(nm, {20'h0, rx_word}, {20'h0, e});
    chk("bits per word", {27'h0, rx_len}, 32'd12);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(8'h5c, d, r);
    chk("readback at reset", d, 32'h0);
    axi_rd(8'h58, d, r);
    chk("read of write-only", {30'h0, r}, 32'h2);
    chk_word("reset data word", 12'h200, 1'b0);
  endtask
  task automatic t_ctrl();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(8'h5c, 8'h1f, r);
    chk("write to readback", {30'h0, r}, 32'h2);
    wr_ok(8'h58, 8'h1b);
    axi_rd(8'h5c, d, r);
    chk("control readback", d, 32'h1b);
  endtask
  task automatic t_train();
    logic [11:0] pat [4];
    pat = '{12'h200, 12'h03f, 12'haaa, 12'ha5c};
    wr_ok(8'h40, 8'h5c);
    wr_ok(8'h48, 8'h0a);
    for (int s = 1; s < 4; s++) begin
      for (int m = 0; m < 2; m++) begin
        wr_ok(8'h58, {5'h00, m[0], s[1:0]});
        chk_word("training word", pat[s], m[0]);
      end
    end
  endtask
  task automatic t_fmt();
    logic [31:0] d;
    logic [1:0] r;
    wr_ok(8'h58, 8'h08);
    chk_word("offset binary", 12'ha00, 1'b0);
    wr_ok(8'h58, 8'h1c);
    chk_word("equalizer msb first", 12'ha00, 1'b1);
    axi_rd(8'h7c, d, r);
    chk("active settings", d, 32'h1c);
    wr_ok(8'h58, 8'h00);
  endtask
  task automatic t_gain();
    wr_ok(8'h54, 8'h80);
    chk_word("overload gain 2.58 dB", 12'h2b1, 1'b0);
    wr_ok(8'h54, 8'h7d);
    chk_word("fine 101 as -2", 12'h200, 1'b0);
    wr_ok(8'h54, 8'h7c);
    chk_word("fine 100 as -2", 12'h200, 1'b0);
    wr_ok(8'h54, 8'h7b);
    chk_word("fine 011 as 2", 12'h24f, 1'b0);
    wr_ok(8'h54, 8'h7e);
    chk_word("unity gain pair", 12'h200, 1'b0);
  endtask
  task automatic summarize();
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    summarize();
  end
  initial begin
    error_cnt = 0;
    checked = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    sample = 12'h200;
    sample_valid = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ctrl();
    t_train();
    t_fmt();
    t_gain();
    summarize();
  end
endmodule
